// ===== design/stpcd_cmd_decoder.sv
// Stepper command decoder: opcode/argument sequencing, responses, flags, Avalon registers
// Behaviour
// RULE1: A command is one opcode byte followed by zero to three argument bytes.
// RULE2: Every received byte answers all zeros unless a read response is pending.
// RULE3: Parameter and status reads return 1 to 3 bytes on following transfers.
// RULE4: A new response-needing command aborts the old response and loads its own.
// RULE5: An undefined opcode is discarded and raises the unknown-command flag.
// RULE6: The all-zero opcode does nothing at all.
// RULE7: Parameter write takes address from low five bits, value msb first.
// RULE8: Writing a read-only register is dropped; unknown flag at opcode end.
// RULE9: Conditional write with condition unmet is dropped; not-performable at last byte.
// RULE10: Writing a nonexistent address is dropped; unknown flag at opcode end.
// RULE11: Parameter read returns register contents msb first, length per register.
// RULE12: Read response is a snapshot taken at opcode decode.
// RULE13: All registers readable anytime; nonexistent address raises unknown flag.
// RULE14: Run takes direction from bit 0 and a 3-byte 0.28 speed.
// RULE15: Run speed is clamped between the configured minimum and maximum.
// RULE16: Run is always accepted at once and holds busy low until done.
// RULE17: External-step command enters external step mode, sets flag, motor reads stopped.
// RULE18: Only run, move or go-to leave external step mode; repeat changes direction.
// RULE19: External-step never drives busy low; rejected while running with not-performable.
// RULE20: Move steps a 3-byte count in bit 0 direction; rejected while running.
// RULE21: Go-to moves to a 3-byte position; rejected while busy is low.
// RULE22: Unknown and not-performable flags are sticky until a status read.
// RULE23: Don't-care argument bits never reach stored targets.
`timescale 1ns/1ps
module stpcd_cmd_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  output logic miso,
  input wire logic motor_running,
  input wire logic motion_done,
  input wire logic [19:0] speed_now,
  input wire logic [21:0] position_now,
  output stpcd_pkg::stpcd_motion_s motion_ff,
  output logic busy_n_ff,
  output logic ext_step_mode_flag_ff,
  output logic pos_load_ff,
  output logic [21:0] pos_value_ff,
  output logic unknown_cmd_flag_ff,
  output logic not_performable_flag_ff,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata_ff,
  output logic avs_waitrequest_ff
);
  stpcd_pkg::stpcd_state_e state_ff;
  stpcd_pkg::stpcd_cmd_e cmd_ff;
  stpcd_pkg::stpcd_cmd_e cmd_now;
  logic [4:0] addr_ff;
  logic [1:0] args_left_ff;
  logic [23:0] arg_ff;
  logic [23:0] arg_next;
  logic [23:0] resp_ff;
  logic [1:0] resp_left_ff;
  logic [19:0] max_speed_ff;
  logic [19:0] min_speed_ff;
  logic [19:0] clamped_speed;
  logic [23:0] read_val;
  logic [15:0] status_word;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [1:0] plen_now;
  logic rx_valid;
  logic op_take;
  logic fin;
  logic bad_op;
  logic run_fin;
  logic move_fin;
  logic absolute_move_cmd_fin;
  logic step_now;
  logic stat_now;
  logic set_fin;
  logic pos_reject;
  logic notperf_set;
  logic av_write;
  logic [31:0] max_merged;
  logic [31:0] min_merged;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode; bits outside each layout must match exactly, anything else is undefined
  function automatic stpcd_pkg::stpcd_cmd_e decode_op(input logic [7:0] b);
    if (b == stpcd_pkg::OP_NOP) decode_op = stpcd_pkg::C_NOP; //RULE6
    else if (b[7:5] == stpcd_pkg::OP_SET_CLASS) decode_op = stpcd_pkg::C_SET;
    else if (b[7:5] == stpcd_pkg::OP_GET_CLASS) decode_op = stpcd_pkg::C_GET;
    else if ((b & stpcd_pkg::OP_DIR_MASK) == stpcd_pkg::OP_RUN) decode_op = stpcd_pkg::C_RUN;
    else if ((b & stpcd_pkg::OP_DIR_MASK) == stpcd_pkg::OP_EXT_STEP) decode_op = stpcd_pkg::C_EXT_STEP;
    else if ((b & stpcd_pkg::OP_DIR_MASK) == stpcd_pkg::OP_MOVE) decode_op = stpcd_pkg::C_MOVE;
    else if (b == stpcd_pkg::OP_ABSOLUTE_MOVE_CMD) decode_op = stpcd_pkg::C_ABSOLUTE_MOVE_CMD;
    else if (b == stpcd_pkg::OP_STATUS) decode_op = stpcd_pkg::C_STATUS;
    else decode_op = stpcd_pkg::C_BAD;
  endfunction

  // Register length in bytes; zero marks a nonexistent address
  function automatic logic [1:0] register_address_field_len(input logic [4:0] a);
    case (a)
      stpcd_pkg::PADDR_POSITION, stpcd_pkg::PADDR_MAX_SPEED,
      stpcd_pkg::PADDR_MIN_SPEED, stpcd_pkg::PADDR_SPEED: register_address_field_len = stpcd_pkg::REGISTER_ADDRESS_FIELD_BYTES;
      default: register_address_field_len = 2'h0;
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) be_merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  stpcd_spi_link u_link (
    .clk(clk),
    .reset_n(reset_n),
    .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin),
    .tx_byte(tx_byte),
    .rx_byte_ff(rx_byte),
    .rx_valid_ff(rx_valid),
    .miso_ff(miso)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode terms
  assign cmd_now = decode_op(rx_byte);
  assign plen_now = register_address_field_len(rx_byte[4:0]);
  assign arg_next = {arg_ff[15:0], rx_byte};
  assign op_take = rx_valid && state_ff == stpcd_pkg::S_OPCODE;
  assign fin = rx_valid && state_ff == stpcd_pkg::S_ARGS && args_left_ff == 2'h1;
  assign bad_op = op_take && (cmd_now == stpcd_pkg::C_BAD //RULE5
    || ((cmd_now == stpcd_pkg::C_SET || cmd_now == stpcd_pkg::C_GET) && plen_now == 2'h0) //RULE10 RULE13
    || (cmd_now == stpcd_pkg::C_SET && rx_byte[4:0] == stpcd_pkg::PADDR_SPEED)); //RULE8
  assign run_fin = fin && cmd_ff == stpcd_pkg::C_RUN;
  assign move_fin = fin && cmd_ff == stpcd_pkg::C_MOVE;
  assign absolute_move_cmd_fin = fin && cmd_ff == stpcd_pkg::C_ABSOLUTE_MOVE_CMD;
  assign set_fin = fin && cmd_ff == stpcd_pkg::C_SET;
  assign step_now = op_take && cmd_now == stpcd_pkg::C_EXT_STEP;
  assign stat_now = op_take && cmd_now == stpcd_pkg::C_STATUS;
  assign pos_reject = set_fin && addr_ff == stpcd_pkg::PADDR_POSITION && motor_running; //RULE9
  assign notperf_set = (move_fin && motor_running) || (absolute_move_cmd_fin && !busy_n_ff) //RULE20 RULE21
    || (step_now && motor_running) || pos_reject; //RULE19 RULE9
  // Don't-care top bits of the speed argument are cut off here
  assign clamped_speed = (arg_next[19:0] > max_speed_ff) ? max_speed_ff : //RULE15 RULE23
    (arg_next[19:0] < min_speed_ff) ? min_speed_ff : arg_next[19:0];
  assign status_word = (16'(ext_step_mode_flag_ff) << stpcd_pkg::ST_EXT_STEP)
    | (16'(unknown_cmd_flag_ff) << stpcd_pkg::ST_UNKNOWN)
    | (16'(not_performable_flag_ff) << stpcd_pkg::ST_NOT_PERF)
    | (16'({2{motor_running && !ext_step_mode_flag_ff}}) << stpcd_pkg::ST_MOT) //RULE17
    | (16'(motion_ff.dir) << stpcd_pkg::ST_DIR)
    | (16'(busy_n_ff) << stpcd_pkg::ST_BUSY);
  assign tx_byte = (resp_left_ff != 2'h0) ? resp_ff[23:16] : 8'h00; //RULE2
  assign max_merged = be_merge({12'h000, max_speed_ff}, avs_writedata, avs_byteenable);
  assign min_merged = be_merge({12'h000, min_speed_ff}, avs_writedata, avs_byteenable);

  always_comb begin
    case (rx_byte[4:0])
      stpcd_pkg::PADDR_POSITION: read_val = {2'h0, position_now};
      stpcd_pkg::PADDR_MAX_SPEED: read_val = {4'h0, max_speed_ff};
      stpcd_pkg::PADDR_MIN_SPEED: read_val = {4'h0, min_speed_ff};
      stpcd_pkg::PADDR_SPEED: read_val = {4'h0, speed_now};
      default: read_val = 24'h000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Opcode and argument sequencing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= stpcd_pkg::S_OPCODE;
      cmd_ff <= stpcd_pkg::C_NOP;
      addr_ff <= 5'h00;
      args_left_ff <= 2'h0;
      arg_ff <= 24'h000000;
    end else if (op_take && !bad_op) begin
      cmd_ff <= cmd_now;
      addr_ff <= rx_byte[4:0]; //RULE7
      arg_ff <= 24'h000000;
      case (cmd_now)
        stpcd_pkg::C_SET: begin
          state_ff <= stpcd_pkg::S_ARGS; //RULE1
          args_left_ff <= plen_now; //RULE7
        end
        stpcd_pkg::C_RUN, stpcd_pkg::C_MOVE, stpcd_pkg::C_ABSOLUTE_MOVE_CMD: begin
          state_ff <= stpcd_pkg::S_ARGS; //RULE1
          args_left_ff <= stpcd_pkg::MOTION_ARG_BYTES;
        end
        default: state_ff <= stpcd_pkg::S_OPCODE;
      endcase
    end else if (rx_valid && state_ff == stpcd_pkg::S_ARGS) begin
      arg_ff <= arg_next;
      args_left_ff <= args_left_ff - 2'h1;
      if (args_left_ff == 2'h1) state_ff <= stpcd_pkg::S_OPCODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new event wins over the clear by status read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unknown_cmd_flag_ff <= 1'b0;
      not_performable_flag_ff <= 1'b0;
    end else begin
      unknown_cmd_flag_ff <= bad_op || (unknown_cmd_flag_ff && !stat_now); //RULE5 RULE22
      not_performable_flag_ff <= notperf_set || (not_performable_flag_ff && !stat_now); //RULE22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response buffer, captured once at decode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_ff <= 24'h000000;
      resp_left_ff <= 2'h0;
    end else if (op_take && cmd_now == stpcd_pkg::C_GET && plen_now != 2'h0) begin
      resp_ff <= read_val; //RULE11 RULE12 RULE4
      resp_left_ff <= plen_now; //RULE3
    end else if (stat_now) begin
      resp_ff <= {status_word, 8'h00}; //RULE4
      resp_left_ff <= stpcd_pkg::STATUS_BYTES; //RULE3
    end else if (rx_valid && resp_left_ff != 2'h0) begin
      resp_ff <= {resp_ff[15:0], 8'h00}; //RULE11
      resp_left_ff <= resp_left_ff - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion targets, busy and external step mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      motion_ff <= '0;
    end else begin
      motion_ff.run_go <= run_fin; //RULE16
      motion_ff.move_go <= move_fin && !motor_running; //RULE20
      motion_ff.absolute_move_cmd_go <= absolute_move_cmd_fin && busy_n_ff; //RULE21
      if (run_fin) begin
        motion_ff.dir <= cmd_ff_dir(addr_ff); //RULE14
        motion_ff.speed <= clamped_speed; //RULE14 RULE15
      end
      if (move_fin && !motor_running) begin
        motion_ff.dir <= cmd_ff_dir(addr_ff); //RULE20
        motion_ff.steps <= arg_next[21:0]; //RULE23
      end
      if (absolute_move_cmd_fin && busy_n_ff) motion_ff.position <= arg_next[21:0]; //RULE21 RULE23
      if (step_now && !motor_running) motion_ff.dir <= rx_byte[0]; //RULE17 RULE18
    end
  end

  // Opcode bit 0 is kept in the low address bit of the latched opcode
  function automatic logic cmd_ff_dir(input logic [4:0] a);
    cmd_ff_dir = a[0];
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_n_ff <= 1'b1;
      ext_step_mode_flag_ff <= 1'b0;
    end else begin
      // A start in the same cycle as a done keeps busy low
      if (run_fin || (move_fin && !motor_running) || (absolute_move_cmd_fin && busy_n_ff)) begin
        busy_n_ff <= 1'b0; //RULE16 RULE20 RULE21
        ext_step_mode_flag_ff <= 1'b0; //RULE18
      end else begin
        if (motion_done) busy_n_ff <= 1'b1;
        if (step_now && !motor_running) ext_step_mode_flag_ff <= 1'b1; //RULE17 RULE19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers; a serial write wins over a bus write in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      max_speed_ff <= stpcd_pkg::RST_MAX_SPEED;
      min_speed_ff <= stpcd_pkg::RST_MIN_SPEED;
      pos_load_ff <= 1'b0;
      pos_value_ff <= 22'h000000;
    end else begin
      pos_load_ff <= set_fin && addr_ff == stpcd_pkg::PADDR_POSITION && !motor_running; //RULE9
      if (set_fin && addr_ff == stpcd_pkg::PADDR_POSITION) pos_value_ff <= arg_next[21:0]; //RULE7
      if (set_fin && addr_ff == stpcd_pkg::PADDR_MAX_SPEED) begin
        max_speed_ff <= arg_next[19:0]; //RULE7
      end else if (av_write && avs_address == stpcd_pkg::OFS_MAX_SPEED) begin
        max_speed_ff <= max_merged[19:0];
      end
      if (set_fin && addr_ff == stpcd_pkg::PADDR_MIN_SPEED) begin
        min_speed_ff <= arg_next[19:0]; //RULE7
      end else if (av_write && avs_address == stpcd_pkg::OFS_MIN_SPEED) begin
        min_speed_ff <= min_merged[19:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle per access, unmapped reads return zero
  assign av_write = avs_write && !avs_waitrequest_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff <= 32'h00000000;
    end else begin
      avs_waitrequest_ff <= !((avs_read || avs_write) && avs_waitrequest_ff);
      if (avs_read && avs_waitrequest_ff) begin
        case (avs_address)
          stpcd_pkg::OFS_STATUS: avs_readdata_ff <= {16'h0000, status_word};
          stpcd_pkg::OFS_MAX_SPEED: avs_readdata_ff <= {12'h000, max_speed_ff};
          stpcd_pkg::OFS_MIN_SPEED: avs_readdata_ff <= {12'h000, min_speed_ff};
          default: avs_readdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_unknown_op_flag: assert property (op_take && cmd_now == stpcd_pkg::C_BAD //RULE5
    |=> unknown_cmd_flag_ff && state_ff == stpcd_pkg::S_OPCODE && !motion_ff.run_go)
    else $error("undefined opcode did not raise unknown flag");
  a_readonly_write_drop: assert property (op_take && cmd_now == stpcd_pkg::C_SET //RULE8
    && rx_byte[4:0] == stpcd_pkg::PADDR_SPEED |=> unknown_cmd_flag_ff && state_ff == stpcd_pkg::S_OPCODE)
    else $error("read-only write not dropped at opcode end");
  a_missing_addr_drop: assert property (op_take && plen_now == 2'h0 //RULE10 RULE13
    && (cmd_now == stpcd_pkg::C_GET || cmd_now == stpcd_pkg::C_SET)
    |=> unknown_cmd_flag_ff && state_ff == stpcd_pkg::S_OPCODE
    && (resp_left_ff == 2'h0 || resp_left_ff == $past(resp_left_ff) - 2'h1))
    else $error("nonexistent address not dropped");
  a_nop_no_change: assert property (op_take && cmd_now == stpcd_pkg::C_NOP && !motion_done //RULE6
    |=> $stable(motion_ff) && $stable(busy_n_ff) && $stable(ext_step_mode_flag_ff))
    else $error("no-operation changed state");
  a_idle_zero_byte: assert property (resp_left_ff == 2'h0 |-> tx_byte == 8'h00) //RULE2
    else $error("nonzero byte offered with no response pending");
  a_read_length: assert property (op_take && cmd_now == stpcd_pkg::C_GET && plen_now != 2'h0 //RULE3 RULE11
    |=> resp_left_ff == 2'h3 && resp_ff == $past(read_val))
    else $error("parameter read response length wrong");
  a_snapshot_hold: assert property (!rx_valid |=> $stable(resp_ff) && $stable(resp_left_ff)) //RULE12
    else $error("response changed without a byte transfer");
  a_abort_reload: assert property (resp_left_ff == 2'h1 && stat_now //RULE4
    |=> resp_left_ff == 2'h2 && resp_ff[7:0] == 8'h00)
    else $error("pending response not replaced by new one");
  a_run_busy_low: assert property (run_fin //RULE16
    |=> !busy_n_ff && motion_ff.run_go ##1 !motion_ff.run_go)
    else $error("run did not start with busy low");
  a_speed_clamped: assert property (motion_ff.run_go && min_speed_ff <= max_speed_ff //RULE15
    |-> motion_ff.speed <= max_speed_ff && motion_ff.speed >= min_speed_ff)
    else $error("run speed outside configured limits");
  a_ext_step_enter: assert property (step_now && !motor_running && !motion_done //RULE17 RULE19
    |=> ext_step_mode_flag_ff && $stable(busy_n_ff) && status_word[stpcd_pkg::ST_MOT] == 1'b0)
    else $error("external step entry wrong");
  a_move_reject: assert property (move_fin && motor_running //RULE20
    |=> !motion_ff.move_go && not_performable_flag_ff)
    else $error("move while running not rejected");
  a_absolute_move_cmd_reject: assert property (absolute_move_cmd_fin && !busy_n_ff //RULE21
    |=> !motion_ff.absolute_move_cmd_go && not_performable_flag_ff)
    else $error("go-to while busy not rejected");
  a_flag_sticky: assert property (not_performable_flag_ff && !stat_now |=> not_performable_flag_ff) //RULE22
    else $error("not-performable flag dropped without status read");
endmodule // stpcd_cmd_decoder

// ===== design/stpcd_pkg.sv
// Shared constants, types and carriers of the stepper command decoder
package stpcd_pkg;
  // Avalon byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MAX_SPEED = 4'h4;
  localparam logic [3:0] OFS_MIN_SPEED = 4'h8;
  // Parameter addresses reachable over the serial link
  localparam logic [4:0] PADDR_POSITION = 5'h01;
  localparam logic [4:0] PADDR_MAX_SPEED = 5'h02;
  localparam logic [4:0] PADDR_MIN_SPEED = 5'h03;
  localparam logic [4:0] PADDR_SPEED = 5'h04;
  localparam logic [1:0] REGISTER_ADDRESS_FIELD_BYTES = 2'h3;
  localparam logic [1:0] STATUS_BYTES = 2'h2;
  localparam logic [1:0] MOTION_ARG_BYTES = 2'h3;
  // Opcodes; bit 0 carries direction where the mask clears it
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RUN = 8'h50;
  localparam logic [7:0] OP_EXT_STEP = 8'h58;
  localparam logic [7:0] OP_MOVE = 8'h40;
  localparam logic [7:0] OP_ABSOLUTE_MOVE_CMD = 8'h60;
  localparam logic [7:0] OP_STATUS = 8'hd0;
  localparam logic [7:0] OP_DIR_MASK = 8'hfe;
  localparam logic [2:0] OP_SET_CLASS = 3'h0;
  localparam logic [2:0] OP_GET_CLASS = 3'h1;
  // Status word bit positions
  localparam int ST_EXT_STEP = 15;
  localparam int ST_UNKNOWN = 8;
  localparam int ST_NOT_PERF = 7;
  localparam int ST_MOT = 5;
  localparam int ST_DIR = 4;
  localparam int ST_BUSY = 1;
  // Reset values
  localparam logic [19:0] RST_MAX_SPEED = 20'h10000;
  localparam logic [19:0] RST_MIN_SPEED = 20'h00000;

  typedef enum logic [3:0] {
    C_NOP, C_BAD, C_SET, C_GET, C_RUN, C_EXT_STEP, C_MOVE, C_ABSOLUTE_MOVE_CMD, C_STATUS
  } stpcd_cmd_e;

  typedef enum logic {S_OPCODE, S_ARGS} stpcd_state_e;

  typedef struct packed {
    logic run_go;
    logic move_go;
    logic absolute_move_cmd_go;
    logic dir;
    logic [19:0] speed;
    logic [21:0] steps;
    logic [21:0] position;
  } stpcd_motion_s;
endpackage

// ===== design/stpcd_spi_link.sv
// Serial byte link: pin synchronisers, byte receive and response shift-out
`timescale 1ns/1ps
module stpcd_spi_link (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte_ff,
  output logic rx_valid_ff,
  output logic miso_ff
);
  logic [1:0] sck_sync_ff;
  logic [1:0] cs_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic sck_prev_ff;
  logic cs_prev_ff;
  logic [2:0] bits_ff;
  logic [7:0] shin_ff;
  logic [7:0] shout_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops per pin; only the second stage feeds edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_sync_ff <= 2'h3;
      cs_sync_ff <= 2'h3;
      mosi_sync_ff <= 2'h0;
      sck_prev_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], sck_pin};
      cs_sync_ff <= {cs_sync_ff[0], cs_n_pin};
      mosi_sync_ff <= {mosi_sync_ff[0], mosi_pin};
      sck_prev_ff <= sck_sync_ff[1];
      cs_prev_ff <= cs_sync_ff[1];
    end
  end

  assign sck_rise = sck_sync_ff[1] && !sck_prev_ff;
  assign sck_fall = !sck_sync_ff[1] && sck_prev_ff;
  assign cs_fall = !cs_sync_ff[1] && cs_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Receive on rising clock edges, msb first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bits_ff <= 3'h0;
      shin_ff <= 8'h00;
      rx_byte_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (cs_sync_ff[1]) begin
        bits_ff <= 3'h0;
      end else if (sck_rise) begin
        shin_ff <= {shin_ff[6:0], mosi_sync_ff[1]};
        bits_ff <= bits_ff + 3'h1;
        if (bits_ff == 3'h7) begin
          rx_byte_ff <= {shin_ff[6:0], mosi_sync_ff[1]};
          rx_valid_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit on falling edges; a new byte is loaded at each byte boundary
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shout_ff <= 8'h00;
      miso_ff <= 1'b0;
    end else if (cs_fall || (sck_fall && !cs_sync_ff[1] && bits_ff == 3'h0)) begin
      shout_ff <= {tx_byte[6:0], 1'b0};
      miso_ff <= tx_byte[7];
    end else if (sck_fall && !cs_sync_ff[1]) begin
      shout_ff <= {shout_ff[6:0], 1'b0};
      miso_ff <= shout_ff[7];
    end
  end
endmodule // stpcd_spi_link

// ===== verif/stpcd_host_model.sv
// Host-side serial master model: mode 3, msb first, one byte per select
`timescale 1ns/1ps
module stpcd_host_model (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'h1;
    cs_n = 1'h1;
    mosi = 1'h1;
  end
  // Half period of 8 clk gives the 160 ns link clock; sck stands still between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    cs_n <= 1'h0;
    for (int i = 7; i >= 0; i--) begin
      repeat (8) @(posedge clk);
      sck <= 1'h0;
      mosi <= tx[i];
      repeat (8) @(posedge clk);
      sck <= 1'h1;
      rx[i] = miso;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'h1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    mosi <= ~tx[0];
    repeat (8) @(posedge clk);
  endtask
endmodule // stpcd_host_model

// ===== verif/stpcd_cmd_decoder_tb.sv
// Self-checking bench of the stepper command decoder
`timescale 1ns/1ps
module stpcd_cmd_decoder_tb;
  logic clk, reset_n, sck, cs_n, mosi, miso, running, done, ext, unk, np, busy_n, rd, wr, wt;
  logic [3:0] adr;
  logic [31:0] wd, q, r;
  logic [21:0] pv;
  stpcd_pkg::stpcd_motion_s mo;
  int error_cnt, comparisons;
  stpcd_cmd_decoder uut (.clk(clk), .reset_n(reset_n), .sck_pin(sck), .cs_n_pin(cs_n), .mosi_pin(mosi),
    .miso(miso), .motor_running(running), .motion_done(done), .speed_now(20'h00abc),
    .position_now(22'h000055), .motion_ff(mo), .busy_n_ff(busy_n), .ext_step_mode_flag_ff(ext),
    .pos_load_ff(), .pos_value_ff(pv), .unknown_cmd_flag_ff(unk), .not_performable_flag_ff(np),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata_ff(q), .avs_waitrequest_ff(wt));
  stpcd_host_model h (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic avm(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wt !== 1'h0 && k < 50);
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge clk);
    if (k == 50) begin
      error_cnt++;
      complete_run();
    end
  endtask
  // Sends n bytes from the top of w; r collects every answer byte
  task automatic cmd(input logic [31:0] w, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      h.xfer(w[31-8*i -: 8], b);
      r = {r[23:0], b};
    end
  endtask
  task automatic t_regs();
    avm(1'h0, stpcd_pkg::OFS_MAX_SPEED, 32'h0);
    chk("max_speed", q, 32'h00010000);
    avm(1'h1, stpcd_pkg::OFS_MIN_SPEED, 32'h00000100);
    avm(1'h0, stpcd_pkg::OFS_MIN_SPEED, 32'h0);
    chk("min_speed", q, 32'h00000100);
    avm(1'h0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_link();
    cmd(32'h0, 1);
    chk("nop_unknown", unk, 32'h0);
    cmd({3'h1, stpcd_pkg::PADDR_MAX_SPEED, 24'h0}, 4);
    chk("read_max", r, 32'h00010000);
    cmd({3'h0, stpcd_pkg::PADDR_SPEED, 24'h0}, 1);
    chk("ro_write", unk, 32'h1);
    cmd(32'hf8000000, 1);
    chk("unknown", unk, 32'h1);
    // Leave one byte of the read pending so the status read must abort it
    cmd({3'h1, stpcd_pkg::PADDR_MIN_SPEED, 24'h0}, 3);
    chk("read_min", r[15:0], 32'h0001);
    cmd({stpcd_pkg::OP_STATUS, 24'h0}, 3);
    chk("status_unknown", r[8], 32'h1);
    chk("unknown_clear", unk, 32'h0);
    cmd({3'h1, 5'h1f, 24'h0}, 1);
    chk("missing_read", unk, 32'h1);
    cmd({3'h0, stpcd_pkg::PADDR_MIN_SPEED, 24'h000200}, 4);
    avm(1'h0, stpcd_pkg::OFS_MIN_SPEED, 32'h0);
    chk("link_write", q, 32'h00000200);
  endtask
  task automatic t_motion();
    cmd(32'h59000000, 1);
    chk("ext_mode", ext, 32'h1);
    chk("ext_busy", busy_n, 32'h1);
    cmd(32'h60c00123, 4);
    chk("absolute_move_cmd_pos", mo.position, 32'h123);
    chk("ext_left", ext, 32'h0);
    chk("absolute_move_cmd_busy", busy_n, 32'h0);
    done <= 1'h1;
    @(posedge clk);
    done <= 1'h0;
    repeat (2) @(posedge clk);
    chk("busy_done", busy_n, 32'h1);
    cmd(32'h51ffffff, 4);
    chk("run_speed", mo.speed, 32'h10000);
    chk("run_dir", mo.dir, 32'h1);
    chk("run_busy", busy_n, 32'h0);
    running <= 1'h1;
    cmd(32'h40000010, 4);
    chk("move_refused", np, 32'h1);
    cmd({stpcd_pkg::OP_STATUS, 24'h0}, 3);
    chk("np_clear", np, 32'h0);
    cmd({3'h0, stpcd_pkg::PADDR_POSITION, 24'h000077}, 4);
    chk("pos_refused", np, 32'h1);
    running <= 1'h0;
    cmd({3'h0, stpcd_pkg::PADDR_POSITION, 24'h000066}, 4);
    chk("pos_value", pv, 32'h66);
    cmd(32'h41000010, 4);
    chk("move_steps", mo.steps, 32'h10);
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset_n = 1'h0;
    {running, done, rd, wr} = 4'h0;
    adr = 4'h0;
    wd = 32'h0;
    r = 32'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_link();
    t_motion();
    complete_run();
  end
endmodule // stpcd_cmd_decoder_tb
